// ### hdl/cpu_interrupt_sequencer.sv
/*
 * Interrupt acceptance and entry sequencing for an 8-bit core.
 * Assumes the core flags the last cycle of each instruction with
 * boundary_i, reports the flag-changing instructions and taken
 * same-page branches in that same cycle, holds pc_i steady during an
 * entry sequence and performs the pushes and vector reads it is told to.
 */
// Summary of operation
// - Maskable request is a level; handler re-enters while it stays active and unmasked.
// - No memory of a maskable request; withdrawn requests never start the handler.
// - Non-maskable assertion edge is latched once, serviced regardless of mask.
// - Further non-maskable edges before acknowledgement are discarded.
// - Interrupts are accepted only at instruction boundaries, never mid-instruction.
// - Entry sequence for all interrupts and software break lasts seven cycles.
// - Clear-mask or pull-flags unmasking delays the interrupt by one instruction.
// - Return unmasking allows the interrupt right after the return.
// - Clear-mask then set-mask, or pull-flags that sets the mask, enters with mask pushed as set.
// - No maskable entry in listed clear/pull/return instruction pairs.
// - Taken same-page branch defers acceptance to after the next instruction.
// - Page-crossing branches and other control flow add no deferral.
// - Non-maskable event early in a maskable entry redirects to its vector.
// - Software break uses the same entry with break flag set in pushed flags.
// - Non-maskable event during break diverts vector, break flag stays set.
// - Maskable request overlapping break lets break finish, taken later if held.
// - Non-maskable edge at the selection cycle is lost; earlier ones take over.
// - No acceptance at the boundary right after an entry sequence.
// - A break as first handler instruction may be taken over by pending events.
`timescale 1ns/1ps

module cpu_interrupt_sequencer (
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	input  wire logic        irq_n_i,
	input  wire logic        nmi_n_i,
	input  wire logic        boundary_i,
	input  wire logic        break_start_i,
	input  wire logic        clear_mask_op_i,
	input  wire logic        set_mask_op_i,
	input  wire logic        pull_flags_op_i,
	input  wire logic        return_op_i,
	input  wire logic        pulled_mask_i,
	input  wire logic        branch_same_page_i,
	input  wire logic [15:0] pc_i,
	input  wire logic [7:0]  flags_i,
	output logic             entry_o,
	output logic [2:0]       seq_cnt_o,
	output logic             push_we_o,
	output logic [7:0]       push_data_o,
	output logic             vector_rd_o,
	output logic [15:0]      vector_addr_o,
	output logic             nmi_vector_o,
	output logic             mask_o
);

	irq_seq_pkg::seq_state_type state_q;
	irq_seq_pkg::seq_state_type state_d;

	logic [1:0] sync_q [irq_seq_pkg::SYNC_STAGES];
	logic [1:0] lvl_q;
	logic       nmi_lvl_old_q;
	logic       nmi_pend_q;
	logic       nmi_pend_d;
	logic       mask_q;
	logic       mask_d;
	logic [2:0] cnt_q;
	logic [2:0] cnt_d;
	logic       brk_q;
	logic       post_entry_q;
	logic       prev_clear_q;
	logic       prev_pullret_q;

	// Pins, active low, through three flops; a change counts when stages 2 and 3 agree
	wire [1:0] pin_active = {~nmi_n_i, ~irq_n_i};

	genvar g;
	generate
		for (g = 0; g < irq_seq_pkg::SYNC_STAGES; g++) begin : g_sync
			if (g == 0) begin : g_first
				always_ff @(posedge clk_i or posedge reset_i) begin
					if (reset_i) begin
						sync_q[g] <= 2'h0;
					end else begin
						sync_q[g] <= pin_active;
					end
				end
			end else begin : g_rest
				always_ff @(posedge clk_i or posedge reset_i) begin
					if (reset_i) begin
						sync_q[g] <= 2'h0;
					end else begin
						sync_q[g] <= sync_q[g-1];
					end
				end
			end
		end
	endgenerate

	wire [1:0] agree = ~(sync_q[1] ^ sync_q[2]);
	wire [1:0] lvl_d = (agree & sync_q[2]) | (~agree & lvl_q);

	wire irq_lvl = lvl_q[0];
	wire nmi_lvl = lvl_q[1];
	wire nmi_edge = nmi_lvl & ~nmi_lvl_old_q;

	wire running = (state_q == irq_seq_pkg::ST_RUN);
	wire in_entry = (state_q == irq_seq_pkg::ST_ENTRY);
	wire bnd = boundary_i & running;
	wire select_cyc = in_entry & (cnt_q == irq_seq_pkg::CYC_SELECT);
	wire last_cyc = in_entry & (cnt_q == irq_seq_pkg::CYC_LAST);

	// Return changes flags early in the instruction, so its pulled mask already counts
	wire mask_poll = return_op_i ? pulled_mask_i : mask_q;

	// Instruction pairs in which no maskable entry may be dispatched
	wire irq_block = (prev_clear_q & return_op_i) |
		(prev_pullret_q & (set_mask_op_i | return_op_i | pull_flags_op_i));

	// Maskable request read straight from the level, never latched
	wire irq_take = irq_lvl & ~mask_poll & ~irq_block;

	// Same-page taken branch defers, other control flow does not
	wire take_int = ~post_entry_q & ~branch_same_page_i
		& (nmi_pend_q | irq_take);

	wire start_int = bnd & take_int;
	wire start_brk = bnd & ~take_int & break_start_i;
	wire start_any = start_int | start_brk;

	// Vector choice made in the flags push cycle, so a late edge can still redirect
	wire nmi_sel = select_cyc & nmi_pend_q;

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		unique case (state_q)
			irq_seq_pkg::ST_RUN: begin
				if (start_any) begin
					state_d = irq_seq_pkg::ST_ENTRY;
					cnt_d = 3'h0;
				end
			end
			irq_seq_pkg::ST_ENTRY: begin
				if (cnt_q == irq_seq_pkg::CYC_LAST) begin
					state_d = irq_seq_pkg::ST_RUN;
					cnt_d = 3'h0;
				end else begin
					cnt_d = cnt_q + 3'h1;
				end
			end
		endcase
	end

	// Acknowledge wins over set; an edge in the selection cycle itself is dropped
	always_comb begin
		if (nmi_edge & ~select_cyc) begin
			nmi_pend_d = 1'b1;
		end else if (nmi_sel) begin
			nmi_pend_d = 1'b0;
		end else begin
			nmi_pend_d = nmi_pend_q;
		end
	end

	always_comb begin
		mask_d = mask_q;
		if (select_cyc) begin
			mask_d = 1'b1;
		end else if (bnd & clear_mask_op_i) begin
			mask_d = 1'b0;
		end else if (bnd & set_mask_op_i) begin
			mask_d = 1'b1;
		end else if (bnd & (pull_flags_op_i | return_op_i)) begin
			mask_d = pulled_mask_i;
		end
	end

	// Pushed flags carry the mask as it stands now, so set-mask after clear shows it set
	wire [7:0] flags_push = {flags_i[7:6], 1'b1, brk_q, flags_i[3], mask_q, flags_i[1:0]};

	wire push_d = (state_d == irq_seq_pkg::ST_ENTRY) & (cnt_d >= irq_seq_pkg::CYC_PUSH_HI)
		& (cnt_d <= irq_seq_pkg::CYC_PUSH_FLG);
	wire vec_d = (state_d == irq_seq_pkg::ST_ENTRY) & (cnt_d >= irq_seq_pkg::CYC_VEC_LO);
	wire nmi_vec_d = nmi_sel | (nmi_vector_o & ~start_any);
	wire [15:0] vec_base = nmi_vec_d ? irq_seq_pkg::VEC_NONMASK : irq_seq_pkg::VEC_MASKABLE;
	wire [15:0] vec_addr_d = (cnt_d == irq_seq_pkg::CYC_VEC_HI) ? vec_base + 16'h0001
		: vec_base;
	wire [7:0] push_data_d = (cnt_d == irq_seq_pkg::CYC_PUSH_HI) ? pc_i[15:8]
		: (cnt_d == irq_seq_pkg::CYC_PUSH_LO) ? pc_i[7:0] : flags_push;

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			lvl_q <= 2'h0;
			nmi_lvl_old_q <= 1'b0;
			nmi_pend_q <= 1'b0;
		end else begin
			lvl_q <= lvl_d;
			nmi_lvl_old_q <= nmi_lvl;
			nmi_pend_q <= nmi_pend_d;
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_q <= irq_seq_pkg::ST_RUN;
			cnt_q <= irq_seq_pkg::CNT_RESET;
			mask_q <= irq_seq_pkg::MASK_RESET;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			mask_q <= mask_d;
		end
	end

	// Break flag held for the whole sequence, even if the vector is redirected
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			brk_q <= 1'b0;
		end else if (start_any) begin
			brk_q <= start_brk;
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			post_entry_q <= 1'b0;
		end else if (last_cyc) begin
			post_entry_q <= 1'b1;
		end else if (bnd) begin
			post_entry_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			prev_clear_q <= 1'b0;
			prev_pullret_q <= 1'b0;
		end else if (bnd) begin
			prev_clear_q <= clear_mask_op_i & ~start_any;
			prev_pullret_q <= (pull_flags_op_i | return_op_i) & ~start_any;
		end else if (in_entry) begin
			prev_clear_q <= 1'b0;
			prev_pullret_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			entry_o <= 1'b0;
			seq_cnt_o <= irq_seq_pkg::CNT_RESET;
			push_we_o <= 1'b0;
			push_data_o <= 8'h00;
			vector_rd_o <= 1'b0;
			vector_addr_o <= 16'h0000;
			nmi_vector_o <= 1'b0;
			mask_o <= irq_seq_pkg::MASK_RESET;
		end else begin
			entry_o <= (state_d == irq_seq_pkg::ST_ENTRY);
			seq_cnt_o <= cnt_d;
			push_we_o <= push_d;
			push_data_o <= push_data_d;
			vector_rd_o <= vec_d;
			vector_addr_o <= vec_addr_d;
			nmi_vector_o <= nmi_vec_d;
			mask_o <= mask_d;
		end
	end

	property p_seq_len;
		@(posedge clk_i) disable iff (reset_i)
		$rose(entry_o) |-> entry_o[*7] ##1 !entry_o;
	endproperty
	a_seq_len: assert property (p_seq_len) else $error("Entry sequence not seven cycles");

	property p_push_order;
		@(posedge clk_i) disable iff (reset_i)
		$rose(entry_o) |-> !push_we_o ##2 (push_we_o && push_data_o == pc_i[15:8])
			##1 push_we_o ##1 push_we_o ##1 (mask_o && vector_rd_o && !push_we_o);
	endproperty
	a_push_order: assert property (p_push_order) else $error("Entry push order wrong");

	property p_break_flag;
		@(posedge clk_i) disable iff (reset_i)
		(push_we_o && seq_cnt_o == irq_seq_pkg::CYC_PUSH_FLG)
			|-> push_data_o[irq_seq_pkg::FLG_BREAK] == brk_q;
	endproperty
	a_break_flag: assert property (p_break_flag) else $error("Break flag wrong");

	property p_boundary_only;
		@(posedge clk_i) disable iff (reset_i)
		$rose(entry_o) |-> $past(boundary_i);
	endproperty
	a_boundary_only: assert property (p_boundary_only) else $error("Entry off boundary");

	property p_no_back_to_back;
		@(posedge clk_i) disable iff (reset_i)
		(bnd && post_entry_q && !break_start_i) |=> !entry_o;
	endproperty
	a_no_back_to_back: assert property (p_no_back_to_back) else $error("Back-to-back entry");

	property p_branch_defer;
		@(posedge clk_i) disable iff (reset_i)
		(bnd && branch_same_page_i && !break_start_i) |=> !entry_o;
	endproperty
	a_branch_defer: assert property (p_branch_defer) else $error("Branch did not defer");

	property p_pair_block;
		@(posedge clk_i) disable iff (reset_i)
		(bnd && prev_pullret_q && set_mask_op_i && !nmi_pend_q && !break_start_i)
			|=> !entry_o;
	endproperty
	a_pair_block: assert property (p_pair_block) else $error("Blocked pair dispatched");

	property p_nmi_latch;
		@(posedge clk_i) disable iff (reset_i)
		(nmi_edge && !select_cyc) |=> nmi_pend_q;
	endproperty
	a_nmi_latch: assert property (p_nmi_latch) else $error("Edge not latched");

	property p_nmi_redirect;
		@(posedge clk_i) disable iff (reset_i)
		(select_cyc && nmi_pend_q) |=> nmi_vector_o &&
			(vector_addr_o == irq_seq_pkg::VEC_NONMASK);
	endproperty
	a_nmi_redirect: assert property (p_nmi_redirect) else $error("No redirect");

	property p_irq_level;
		@(posedge clk_i) disable iff (reset_i)
		(bnd && !nmi_pend_q && !break_start_i && !post_entry_q && !branch_same_page_i
			&& !return_op_i && !irq_block && irq_lvl && !mask_q) |=> entry_o;
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("Request not taken");

	c_irq_entry: cover property (@(posedge clk_i) disable iff (reset_i)
		start_int && !nmi_pend_q);
	c_nmi_hijack: cover property (@(posedge clk_i) disable iff (reset_i)
		nmi_sel && brk_q);
	c_clear_set: cover property (@(posedge clk_i) disable iff (reset_i)
		start_int && set_mask_op_i);

endmodule

// ### hdl/irq_seq_pkg.sv
/*
 * Constants shared by the interrupt sequencer: entry sequence cycle
 * positions, vector addresses, pushed flags layout and reset values.
 * Assumes an 8-bit core with a 16-bit program counter.
 */
package irq_seq_pkg;

	// Entry sequence length and cycle positions within it
	localparam int unsigned SEQ_LEN      = 7;
	localparam logic [2:0]  CYC_LAST     = 3'h6;
	localparam logic [2:0]  CYC_PUSH_HI  = 3'h2;
	localparam logic [2:0]  CYC_PUSH_LO  = 3'h3;
	localparam logic [2:0]  CYC_PUSH_FLG = 3'h4;
	localparam logic [2:0]  CYC_VEC_LO   = 3'h5;
	localparam logic [2:0]  CYC_VEC_HI   = 3'h6;
	// Vector choice is made in the flags push cycle
	localparam logic [2:0]  CYC_SELECT   = 3'h4;

	// Vector low-byte addresses
	localparam logic [15:0] VEC_NONMASK  = 16'hfffa;
	localparam logic [15:0] VEC_MASKABLE = 16'hfffe;

	// Pushed flags byte fields
	localparam int unsigned FLG_MASK     = 2;
	localparam int unsigned FLG_BREAK    = 4;
	localparam int unsigned FLG_ONE      = 5;

	// Reset values
	localparam logic        MASK_RESET   = 1'b1;
	localparam logic [2:0]  CNT_RESET    = 3'h0;

	// Pin synchroniser depth
	localparam int unsigned SYNC_STAGES  = 3;

	typedef enum logic {
		ST_RUN,
		ST_ENTRY
	} seq_state_type;

endpackage

// ### verification/irq_source_model.sv
/*
 * Peripheral side model driving both request pins.
 * Assumes the bench commands it from the falling clock edge.
 */
`timescale 1ns/1ps

module irq_source_model (
	input  wire logic clk_i,
	input  wire logic irq_hold_i,
	input  wire logic nmi_fire_i,
	output logic      irq_n_o,
	output logic      nmi_n_o
);
	logic [2:0] nmi_cnt_q = 3'h0;

	// Level held low until the handler has serviced the source
	assign irq_n_o = !irq_hold_i;
	// Event pin pulled low long enough to pass the pin filter
	assign nmi_n_o = (nmi_cnt_q == 3'h0);

	always_ff @(posedge clk_i) begin
		if (nmi_fire_i) begin
			nmi_cnt_q <= 3'h6;
		end else if (nmi_cnt_q != 3'h0) begin
			nmi_cnt_q <= nmi_cnt_q - 3'h1;
		end
	end
endmodule

// ### verification/tb_cpu_interrupt_sequencer.sv
/*
 * Self-checking bench for the interrupt sequencer.
 * Assumes the peripheral model drives the pins and the bench plays the core.
 */
`timescale 1ns/1ps

module tb_cpu_interrupt_sequencer;
	logic        clk_i = 1'b0;
	logic        reset_i = 1'b1;
	logic        irq_n, nmi_n, irq_hold = 1'b0, nmi_fire = 1'b0;
	logic        boundary_i = 1'b0, break_start_i = 1'b0, branch_same_page_i = 1'b0;
	logic        clear_mask_op_i = 1'b0, set_mask_op_i = 1'b0;
	logic        pull_flags_op_i = 1'b0, return_op_i = 1'b0, pulled_mask_i = 1'b0;
	logic [15:0] pc_i = 16'h5a3c;
	logic [7:0]  flags_i = 8'h00;
	logic        entry_o, push_we_o, vector_rd_o, nmi_vector_o, mask_o;
	logic [2:0]  seq_cnt_o;
	logic [7:0]  push_data_o;
	logic [15:0] vector_addr_o;
	int          n_mismatch = 0;
	int          total_checks = 0;

	always #10 clk_i = !clk_i;

	irq_source_model u_src (.clk_i(clk_i), .irq_hold_i(irq_hold), .nmi_fire_i(nmi_fire),
		.irq_n_o(irq_n), .nmi_n_o(nmi_n));

	cpu_interrupt_sequencer u_dut (.clk_i(clk_i), .reset_i(reset_i), .irq_n_i(irq_n),
		.nmi_n_i(nmi_n), .boundary_i(boundary_i), .break_start_i(break_start_i),
		.clear_mask_op_i(clear_mask_op_i), .set_mask_op_i(set_mask_op_i),
		.pull_flags_op_i(pull_flags_op_i), .return_op_i(return_op_i),
		.pulled_mask_i(pulled_mask_i), .branch_same_page_i(branch_same_page_i),
		.pc_i(pc_i), .flags_i(flags_i), .entry_o(entry_o), .seq_cnt_o(seq_cnt_o),
		.push_we_o(push_we_o), .push_data_o(push_data_o), .vector_rd_o(vector_rd_o),
		.vector_addr_o(vector_addr_o), .nmi_vector_o(nmi_vector_o), .mask_o(mask_o));

	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(negedge clk_i);
	endtask

	// One instruction end; entry_o is settled on return
	task automatic bnd(input logic clr, set, pull, ret, pulled, software_break_op, br);
		@(negedge clk_i);
		{boundary_i, clear_mask_op_i, set_mask_op_i, pull_flags_op_i} = {1'b1, clr, set, pull};
		{return_op_i, pulled_mask_i, break_start_i, branch_same_page_i} = {ret, pulled, software_break_op, br};
		@(negedge clk_i);
		{boundary_i, clear_mask_op_i, set_mask_op_i, pull_flags_op_i} = 4'h0;
		{return_op_i, pulled_mask_i, break_start_i, branch_same_page_i} = 4'h0;
	endtask

	// Follows a whole entry sequence from its first cycle
	task automatic walk(input logic nmi, input logic [7:0] flg);
		logic [15:0] vec;
		vec = nmi ? irq_seq_pkg::VEC_NONMASK : irq_seq_pkg::VEC_MASKABLE;
		for (int k = 0; k < 8; k++) begin
			chk("entry_o", entry_o, k < 7);
			if (k == 2) chk("push_hi", push_data_o, pc_i[15:8]);
			if (k == 3) chk("push_lo", push_data_o, pc_i[7:0]);
			if (k == 4) chk("push_flags", push_data_o, flg);
			if (k == 5) chk("vec_lo", vector_addr_o, vec);
			if (k == 5) chk("mask_o", mask_o, 1'b1);
			if (k == 6) chk("vec_hi", vector_addr_o, vec + 16'h1);
			chk("seq_cnt_o", seq_cnt_o, (k < 7) ? 16'(k) : 16'h0);
			chk("push_we_o", push_we_o, k >= 2 && k <= 4);
			chk("vector_rd_o", vector_rd_o, k == 5 || k == 6);
			if (k == 5) chk("nmi_vector_o", nmi_vector_o, nmi);
			@(negedge clk_i);
		end
	endtask

	task automatic t_withdrawn();
		irq_hold = 1'b1;
		wait_cyc(6);
		irq_hold = 1'b0;
		wait_cyc(6);
		bnd(1, 0, 0, 0, 0, 0, 0);
		chk("entry_o", entry_o, 1'b0);
		bnd(0, 0, 0, 0, 0, 0, 0);
		chk("entry_o", entry_o, 1'b0);
		$display("test withdrawn done");
	endtask

	task automatic t_irq_level();
		irq_hold = 1'b1;
		wait_cyc(6);
		bnd(0, 0, 0, 0, 0, 0, 0);
		walk(1'b0, 8'h20);
		// Unmasking return as first handler instruction must still not enter
		bnd(0, 0, 0, 1, 0, 0, 0);
		chk("entry_o", entry_o, 1'b0);
		bnd(0, 0, 0, 0, 0, 0, 0);
		walk(1'b0, 8'h20);
		bnd(0, 0, 0, 0, 0, 0, 0);
		bnd(0, 0, 0, 1, 0, 0, 0);
		walk(1'b0, 8'h20);
		irq_hold = 1'b0;
		wait_cyc(6);
		bnd(0, 0, 0, 0, 0, 0, 0);
		bnd(0, 0, 0, 1, 0, 0, 0);
		chk("entry_o", entry_o, 1'b0);
		$display("test irq_level done");
	endtask

	task automatic t_branch();
		irq_hold = 1'b1;
		wait_cyc(6);
		bnd(0, 0, 0, 0, 0, 0, 1);
		chk("entry_o", entry_o, 1'b0);
		bnd(0, 0, 0, 0, 0, 0, 0);
		walk(1'b0, 8'h20);
		irq_hold = 1'b0;
		wait_cyc(6);
		$display("test branch done");
	endtask

	task automatic t_nmi();
		// First handler instruction, so the boundary after it may accept
		bnd(0, 0, 0, 0, 0, 0, 0);
		nmi_fire = 1'b1;
		@(negedge clk_i);
		nmi_fire = 1'b0;
		wait_cyc(8);
		bnd(0, 0, 0, 0, 0, 0, 0);
		walk(1'b1, 8'h24);
		bnd(0, 0, 0, 0, 0, 0, 0);
		for (int i = 0; i < 2; i++) begin
			nmi_fire = 1'b1;
			@(negedge clk_i);
			nmi_fire = 1'b0;
			wait_cyc(9);
		end
		bnd(0, 0, 0, 0, 0, 0, 0);
		walk(1'b1, 8'h24);
		bnd(0, 0, 0, 0, 0, 0, 0);
		bnd(0, 0, 0, 0, 0, 0, 0);
		chk("entry_o", entry_o, 1'b0);
		$display("test nmi done");
	endtask

	task automatic t_break();
		bnd(0, 0, 0, 0, 0, 1, 0);
		walk(1'b0, 8'h34);
		nmi_fire = 1'b1;
		@(negedge clk_i);
		nmi_fire = 1'b0;
		wait_cyc(8);
		bnd(0, 0, 0, 0, 0, 1, 0);
		walk(1'b1, 8'h34);
		$display("test break done");
	endtask

	task automatic t_clear_set();
		irq_hold = 1'b1;
		wait_cyc(6);
		bnd(1, 0, 0, 0, 0, 0, 0);
		chk("entry_o", entry_o, 1'b0);
		bnd(0, 1, 0, 0, 0, 0, 0);
		walk(1'b0, 8'h24);
		bnd(1, 0, 0, 0, 0, 0, 0);
		bnd(0, 0, 0, 1, 0, 0, 0);
		chk("entry_o", entry_o, 1'b0);
		irq_hold = 1'b0;
		$display("test clear_set done");
	endtask

	initial begin
		wait_cyc(16);
		reset_i = 1'b0;
		chk("mask_o", mask_o, 1'b1);
		t_withdrawn();
		t_irq_level();
		t_branch();
		t_nmi();
		t_break();
		t_clear_set();
		finish_test();
	end

	initial begin
		wait_cyc(20000);
		n_mismatch++;
		finish_test();
	end
endmodule
